/* File: design/qpv_top.sv */
/*
  quadrature encoder position and velocity block with apb register file.
  assumes one clock pclk, asynchronous active-low presetn, and encoder pins
  asynchronous to pclk.
*/
// Chosen here: the placing of the registers and the APB interface to the registers.
// Overview of operation
// R1 - reading the position register returns the live position counter
// R2 - in index reset mode alignment begins only at the first index pulse
// R3 - writing the position register loads the counter; counting continues from it
// R4 - velocity predivider divides count pulses by 1 to 128 in powers of two
// R5 - only predivided pulses are added into the velocity accumulator
// R6 - after the period the accumulator is latched to the result and cleared
// R7 - software programs a nonzero period in clock ticks
// R8 - software sets predivider and period before enabling velocity capture
// R9 - no velocity accumulation while the whole block is disabled
// R10 - reading velocity returns pulses of the last completed period
// R11 - clearing velocity enable stops capture, position keeps working
// R12 - option counts edges of the first phase only or both phases
// R13 - index in reset mode clears position, or loads maximum when reversing
// R14 - options select clock/direction inputs and swap the two inputs
// R15 - simultaneous change of both phase inputs raises the error flag
// R16 - position counts up when forward and down when reverse
`timescale 1ns/1ps
`default_nettype none
module qpv_top #(
  parameter int POS_W = 32,
  parameter int VEL_W = 32
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // encoder pins
  input  wire logic        first_phase_input,
  input  wire logic        second_phase_input,
  input  wire logic        index_input
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                      enable_ff, vel_en_ff, count_both_phases_ff;
  logic                      reset_on_index_mode_ff, clock_direction_input_mode_ff;
  logic                      swap_phase_inputs_ff;
  logic [qpv_pkg::PDIV_W-1:0] velocity_predivider_ff;
  logic [POS_W-1:0]          maximum_position_ff, pos_ff;
  logic [31:0]               velocity_period_ticks_ff;
  logic                      dir_ff, idx_seen_ff;
  logic [qpv_pkg::IRQ_W-1:0] ist_ff, ien_ff, nxt_ist, irq_ev;
  logic                      count_pulse, count_fwd, error_pulse, index_pulse;
  logic [VEL_W-1:0]          vel_ff;
  logic                      period_done;
  logic                      setup, wr, pos_load;

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  qpv_decode u_decode (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .first_phase_input          (first_phase_input),
    .second_phase_input         (second_phase_input),
    .index_input                (index_input),
    .swap_phase_inputs          (swap_phase_inputs_ff),
    .clock_direction_input_mode (clock_direction_input_mode_ff),
    .count_both_phases          (count_both_phases_ff),
    .count_pulse                (count_pulse),
    .count_fwd                  (count_fwd),
    .error_pulse                (error_pulse),
    .index_pulse                (index_pulse)
  );

  // velocity needs the whole block enabled too; its result survives a stop
  qpv_velocity #(.VEL_W(VEL_W)) u_velocity (
    .pclk                  (pclk),
    .presetn               (presetn),
    .run                   (enable_ff & vel_en_ff), // R9 R11
    .velocity_predivider   (velocity_predivider_ff),
    .velocity_period_ticks (velocity_period_ticks_ff),
    .count_pulse           (count_pulse),
    .vel_ff                (vel_ff),
    .done_ff               (period_done)
  );

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {qpv_pkg::OFF_CTRL, qpv_pkg::OFF_MAXP, qpv_pkg::OFF_POS,
                       qpv_pkg::OFF_VPER, qpv_pkg::OFF_VEL, qpv_pkg::OFF_STAT,
                       qpv_pkg::OFF_ISTAT, qpv_pkg::OFF_IEN, qpv_pkg::OFF_ICLR};
  endfunction : mapped

  function automatic logic [31:0] ctrl_word();
    logic [31:0] w;
    w = 32'h0;
    w[qpv_pkg::CTL_EN]   = enable_ff;
    w[qpv_pkg::CTL_VEN]  = vel_en_ff;
    w[qpv_pkg::CTL_BOTH] = count_both_phases_ff;
    w[qpv_pkg::CTL_RIDX] = reset_on_index_mode_ff;
    w[qpv_pkg::CTL_CDIR] = clock_direction_input_mode_ff;
    w[qpv_pkg::CTL_SWAP] = swap_phase_inputs_ff;
    w[qpv_pkg::CTL_PDIV +: qpv_pkg::PDIV_W] = velocity_predivider_ff;
    ctrl_word = w;
  endfunction : ctrl_word

  // one wait-free access: pready rises for the access cycle only
  assign setup    = psel & ~penable & ~pready;
  assign wr       = psel & penable & pready & pwrite & ~pslverr;
  assign pos_load = wr & (paddr == qpv_pkg::OFF_POS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup && !pwrite) begin
        unique case (paddr)
          qpv_pkg::OFF_CTRL:  prdata <= ctrl_word();
          qpv_pkg::OFF_MAXP:  prdata <= 32'(maximum_position_ff);
          qpv_pkg::OFF_POS:   prdata <= 32'(pos_ff); // R1
          qpv_pkg::OFF_VPER:  prdata <= velocity_period_ticks_ff;
          qpv_pkg::OFF_VEL:   prdata <= 32'(vel_ff); // R10
          qpv_pkg::OFF_STAT:  prdata <= 32'({idx_seen_ff, dir_ff});
          qpv_pkg::OFF_ISTAT: prdata <= 32'(ist_ff);
          qpv_pkg::OFF_IEN:   prdata <= 32'(ien_ff);
          default:            prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff                     <= 1'b0;
      vel_en_ff                     <= 1'b0;
      count_both_phases_ff          <= 1'b0;
      reset_on_index_mode_ff        <= 1'b0;
      clock_direction_input_mode_ff <= 1'b0;
      swap_phase_inputs_ff          <= 1'b0;
      velocity_predivider_ff        <= qpv_pkg::PREDIVIDE_BY_ONE;
      maximum_position_ff           <= POS_W'(qpv_pkg::MAXP_RST);
      velocity_period_ticks_ff      <= qpv_pkg::VPER_RST;
      ien_ff                        <= '0;
    end else if (wr) begin
      unique case (paddr)
        qpv_pkg::OFF_CTRL: begin
          enable_ff                     <= pwdata[qpv_pkg::CTL_EN];
          vel_en_ff                     <= pwdata[qpv_pkg::CTL_VEN]; // R11
          count_both_phases_ff          <= pwdata[qpv_pkg::CTL_BOTH]; // R12
          reset_on_index_mode_ff        <= pwdata[qpv_pkg::CTL_RIDX];
          clock_direction_input_mode_ff <= pwdata[qpv_pkg::CTL_CDIR]; // R14
          swap_phase_inputs_ff          <= pwdata[qpv_pkg::CTL_SWAP]; // R14
          velocity_predivider_ff        <= pwdata[qpv_pkg::CTL_PDIV +: qpv_pkg::PDIV_W];
        end
        qpv_pkg::OFF_MAXP: maximum_position_ff      <= pwdata[POS_W-1:0];
        qpv_pkg::OFF_VPER: velocity_period_ticks_ff <= pwdata;
        qpv_pkg::OFF_IEN:  ien_ff                   <= pwdata[qpv_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // position counter
  // ----------------------------------------------------------------------
  // the count wraps between zero and maximum, but a software load can place it outside that range
  // a software load wins over any encoder event in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= '0;
    end else if (pos_load) begin
      pos_ff <= pwdata[POS_W-1:0]; // R3
    end else if (enable_ff && index_pulse && reset_on_index_mode_ff) begin
      pos_ff <= dir_ff ? '0 : maximum_position_ff; // R13
    end else if (enable_ff && count_pulse) begin
      if (count_fwd) begin
        pos_ff <= (pos_ff == maximum_position_ff) ? '0 : pos_ff + 1'b1; // R16
      end else begin
        pos_ff <= (pos_ff == '0) ? maximum_position_ff : pos_ff - 1'b1; // R16
      end
    end
  end

  // alignment restarts on load or on enabling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_seen_ff <= 1'b0;
      dir_ff      <= 1'b1;
    end else begin
      if (pos_load || (wr && paddr == qpv_pkg::OFF_CTRL && !enable_ff)) begin
        idx_seen_ff <= 1'b0; // R2
      end else if (enable_ff && index_pulse) begin
        idx_seen_ff <= 1'b1; // R2
      end
      if (enable_ff && count_pulse) begin
        dir_ff <= count_fwd;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_ev                   = '0;
    irq_ev[qpv_pkg::IRQ_ERR] = enable_ff & error_pulse; // R15
    irq_ev[qpv_pkg::IRQ_IDX] = enable_ff & index_pulse;
    irq_ev[qpv_pkg::IRQ_TMR] = period_done;
    nxt_ist                  = ist_ff;
    if (wr && paddr == qpv_pkg::OFF_ICLR) begin
      nxt_ist = ist_ff & ~pwdata[qpv_pkg::IRQ_W-1:0];
    end
    // an event in the clearing cycle is kept
    nxt_ist = nxt_ist | irq_ev;
  end

  // irq is built from the next status, so it rises with the sticky bit

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= '0;
      irq    <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      irq    <= |(nxt_ist & ien_ff);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pos_read_a: assert property ( // R1
    (setup && !pwrite && paddr == qpv_pkg::OFF_POS) |=> prdata == 32'($past(pos_ff)))
    else $error("position read mismatch");
  pos_load_a: assert property ( // R3
    pos_load |=> pos_ff == $past(pwdata[POS_W-1:0]))
    else $error("position load lost");
  load_unalign_a: assert property ( // R2
    pos_load |=> !idx_seen_ff)
    else $error("alignment not restarted by load");
  pos_up_a: assert property ( // R16
    (enable_ff && count_pulse && count_fwd && !pos_load && !index_pulse
     && pos_ff != maximum_position_ff) |=> pos_ff == $past(pos_ff) + 1'b1)
    else $error("forward count missed");
  pos_down_a: assert property ( // R16
    (enable_ff && count_pulse && !count_fwd && !pos_load && !index_pulse
     && pos_ff != '0) |=> pos_ff == $past(pos_ff) - 1'b1)
    else $error("reverse count missed");
  index_reset_a: assert property ( // R13
    (enable_ff && index_pulse && reset_on_index_mode_ff && !pos_load && !dir_ff)
    |=> pos_ff == $past(maximum_position_ff))
    else $error("reverse index did not load maximum");
  vel_read_a: assert property ( // R10
    (setup && !pwrite && paddr == qpv_pkg::OFF_VEL) |=> prdata == 32'($past(vel_ff)))
    else $error("velocity read mismatch");
  error_flag_a: assert property ( // R15
    (enable_ff && error_pulse) |=> ist_ff[qpv_pkg::IRQ_ERR])
    else $error("error flag not set");
  vel_stop_a: assert property ( // R11
    (!vel_en_ff && !period_done) |=> $stable(vel_ff))
    else $error("velocity changed while stopped");
  irq_level_a: assert property (
    |(ist_ff & ien_ff) |-> ##[0:1] irq)
    else $error("enabled status not reflected on irq");
  irq_match_a: assert property (
    $stable(ien_ff) |-> irq == |(ist_ff & ien_ff))
    else $error("irq does not follow enabled status");
  index_fwd_a: assert property ( // R13
    (enable_ff && index_pulse && reset_on_index_mode_ff && !pos_load && dir_ff)
    |=> pos_ff == '0)
    else $error("forward index did not clear position");
  idx_seen_a: assert property ( // R2
    (enable_ff && index_pulse && !pos_load) |=> idx_seen_ff)
    else $error("index pulse not recorded");
  pos_hold_a: assert property (
    (!enable_ff && !pos_load) |=> $stable(pos_ff))
    else $error("position moved while disabled");
  bad_addr_a: assert property (
    (setup && !mapped(paddr)) |=> pslverr)
    else $error("unmapped address not refused");

  load_c:  cover property (pos_load ##[1:20] (enable_ff && count_pulse));
  index_c: cover property (enable_ff && index_pulse && reset_on_index_mode_ff);
  irq_c:   cover property ($rose(irq));
  err_c:   cover property (enable_ff && error_pulse);
endmodule : qpv_top
`default_nettype wire

/* File: design/qpv_pkg.sv */
/*
  register map, field layout, reset values and encodings of the quadrature
  position and velocity block.
  assumes a 32-bit apb slave with byte addresses and one word per register.
*/
package qpv_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam logic [7:0]  OFF_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_MAXP  = 8'h04;
  localparam logic [7:0]  OFF_POS   = 8'h08;
  localparam logic [7:0]  OFF_VPER  = 8'h0c;
  localparam logic [7:0]  OFF_VEL   = 8'h10;
  localparam logic [7:0]  OFF_STAT  = 8'h14;
  localparam logic [7:0]  OFF_ISTAT = 8'h18;
  localparam logic [7:0]  OFF_IEN   = 8'h1c;
  localparam logic [7:0]  OFF_ICLR  = 8'h20;
  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  localparam int          CTL_EN    = 0;
  localparam int          CTL_VEN   = 1;
  localparam int          CTL_BOTH  = 2;
  localparam int          CTL_RIDX  = 3;
  localparam int          CTL_CDIR  = 4;
  localparam int          CTL_SWAP  = 5;
  localparam int          CTL_PDIV  = 8;
  localparam int          PDIV_W    = 3;
  localparam logic [2:0]  PREDIVIDE_BY_ONE = 3'h0;
  localparam logic [2:0]  PREDIVIDE_BY_128 = 3'h7;
  localparam int          PDIV_CNT_W = 7;
  // ----------------------------------------------------------------------
  // status and interrupt fields
  // ----------------------------------------------------------------------
  localparam int          ST_DIR    = 0;
  localparam int          ST_ISEEN  = 1;
  localparam int          IRQ_W     = 3;
  localparam int          IRQ_ERR   = 0;
  localparam int          IRQ_IDX   = 1;
  localparam int          IRQ_TMR   = 2;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] MAXP_RST  = 32'hffffffff;
  localparam logic [31:0] VPER_RST  = 32'h00000001;
endpackage : qpv_pkg

/* File: design/qpv_decode.sv */
/*
  phase input conditioning: three-stage synchronisers, agreement filter,
  swap and clock/direction selection, edge and direction decoding.
  assumes pins are asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module qpv_decode (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // encoder pins
  input  wire logic first_phase_input,
  input  wire logic second_phase_input,
  input  wire logic index_input,
  // configuration
  input  wire logic swap_phase_inputs,
  input  wire logic clock_direction_input_mode,
  input  wire logic count_both_phases,
  // decoded events
  output logic      count_pulse,
  output logic      count_fwd,
  output logic      error_pulse,
  output logic      index_pulse
);
  // ----------------------------------------------------------------------
  // synchronise and filter: {index, second, first}
  // ----------------------------------------------------------------------
  logic [2:0] s0_ff, s1_ff, s2_ff, flt_ff, prv_ff;
  logic       a_now, b_now, a_old, b_old, a_chg, b_chg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_ff <= 3'h0;
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
    end else begin
      s0_ff <= {index_input, second_phase_input, first_phase_input};
      s1_ff <= s0_ff;
      s2_ff <= s1_ff;
    end
  end

  // a level counts only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_ff <= 3'h0;
      prv_ff <= 3'h0;
    end else begin
      flt_ff <= (s1_ff & ~(s1_ff ^ s2_ff)) | (flt_ff & (s1_ff ^ s2_ff));
      prv_ff <= flt_ff;
    end
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  assign a_now = swap_phase_inputs ? flt_ff[1] : flt_ff[0]; // R14
  assign b_now = swap_phase_inputs ? flt_ff[0] : flt_ff[1]; // R14
  assign a_old = swap_phase_inputs ? prv_ff[1] : prv_ff[0];
  assign b_old = swap_phase_inputs ? prv_ff[0] : prv_ff[1];
  assign a_chg = a_now ^ a_old;
  assign b_chg = b_now ^ b_old;
  assign index_pulse = flt_ff[2] & ~prv_ff[2];

  always_comb begin
    count_pulse = 1'b0;
    count_fwd   = 1'b1;
    error_pulse = 1'b0;
    if (clock_direction_input_mode) begin
      // rising clock edge counts, direction low means forward
      count_pulse = a_chg & a_now; // R14
      count_fwd   = ~b_now;
    end else if (a_chg && b_chg) begin
      error_pulse = 1'b1; // R15
    end else if (a_chg) begin
      count_pulse = 1'b1;
      count_fwd   = a_now ^ b_now;
    end else if (b_chg) begin
      count_pulse = count_both_phases; // R12
      count_fwd   = ~(a_now ^ b_now);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  dual_change_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (!clock_direction_input_mode && a_chg && b_chg) |-> (error_pulse && !count_pulse))
    else $error("simultaneous phase change not flagged");
  single_phase_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (!clock_direction_input_mode && !count_both_phases && !a_chg) |-> !count_pulse)
    else $error("second phase counted in single phase mode");
endmodule : qpv_decode
`default_nettype wire

/* File: design/qpv_velocity.sv */
/*
  velocity capture: predivider, period timer, accumulator and result latch.
  assumes count pulses are one cycle wide and on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module qpv_velocity #(
  parameter int VEL_W = 32
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // control
  input  wire logic                   run,
  input  wire logic [qpv_pkg::PDIV_W-1:0] velocity_predivider,
  input  wire logic [31:0]            velocity_period_ticks,
  input  wire logic                   count_pulse,
  // results
  output logic [VEL_W-1:0]            vel_ff,
  output logic                        done_ff
);
  localparam int CW = qpv_pkg::PDIV_CNT_W;

  function automatic logic [CW-1:0] div_mask(input logic [2:0] sel);
    div_mask = CW'((8'h01 << sel) - 8'h01);
  endfunction : div_mask

  logic [CW-1:0]    pdc_ff;
  logic [31:0]      tick_ff;
  logic [VEL_W-1:0] acc_ff;
  logic             div_pulse, period_end;

  // ----------------------------------------------------------------------
  // predivider
  // ----------------------------------------------------------------------
  assign div_pulse = run & count_pulse
                   & (&(pdc_ff | ~div_mask(velocity_predivider))); // R4 R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdc_ff <= '0;
    end else if (!run) begin
      pdc_ff <= '0;
    end else if (count_pulse) begin
      pdc_ff <= div_pulse ? '0 : pdc_ff + 1'b1; // R4
    end
  end

  // ----------------------------------------------------------------------
  // period timer and accumulator
  // ----------------------------------------------------------------------
  assign period_end = run & ((tick_ff + 32'h1) == velocity_period_ticks);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 32'h0;
      acc_ff  <= '0;
    end else if (!run) begin
      tick_ff <= 32'h0; // R9 R11
      acc_ff  <= '0;
    end else if (period_end) begin
      tick_ff <= 32'h0; // R6
      acc_ff  <= '0;
    end else begin
      tick_ff <= tick_ff + 32'h1;
      acc_ff  <= acc_ff + VEL_W'(div_pulse); // R5
    end
  end

  // result holds the last completed period, also while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= period_end;
      if (period_end) begin
        vel_ff <= acc_ff + VEL_W'(div_pulse); // R6 R10
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  halted_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    !run |=> (acc_ff == '0 && tick_ff == 32'h0))
    else $error("accumulation while halted");
  period_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    period_end |=> (vel_ff == $past(acc_ff) + VEL_W'($past(div_pulse)) && acc_ff == '0))
    else $error("velocity not latched at period end");
  predivide_one_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (run && count_pulse && velocity_predivider == qpv_pkg::PREDIVIDE_BY_ONE) |-> div_pulse)
    else $error("divide by one dropped a pulse");
  period_done_c: cover property (@(posedge pclk) disable iff (!presetn)
    period_end && acc_ff != '0);
endmodule : qpv_velocity
`default_nettype wire

/* File: verification/qpv_enc_model.sv */
/*
  encoder partner: two quadrature phases, an index pin, a forced double change.
  assumes one-cycle step requests on pclk from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module qpv_enc_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // step requests
  input  wire logic step_fwd,
  input  wire logic step_rev,
  input  wire logic step_both,
  input  wire logic index_req,
  // encoder pins
  output logic      phase_a,
  output logic      phase_b,
  output logic      index_out
);
  logic [1:0] st_ff;
  // ----------------------------------------------------------------------
  // phase state
  // ----------------------------------------------------------------------
  // forward order is 00,10,11,01; both pins move only when asked to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      st_ff <= 2'h0;
    else if (step_fwd)
      st_ff <= st_ff + 2'h1;
    else if (step_rev)
      st_ff <= st_ff - 2'h1;
    else if (step_both)
      st_ff <= st_ff + 2'h2;
  end
  assign phase_a   = st_ff[0] ^ st_ff[1];
  assign phase_b   = st_ff[1];
  assign index_out = index_req;
endmodule : qpv_enc_model
`default_nettype wire

/* File: verification/qpv_top_tb.sv */
/*
  bench of qpv_top: apb tasks, encoder partner, directed checks.
  assumes a zero-wait apb slave on a 100 ns pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module qpv_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        fa, fb, fi, sf, sr, sb, ix;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_mismatch, num_checks, n;
  qpv_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .first_phase_input(fa), .second_phase_input(fb),
    .index_input(fi));
  qpv_enc_model enc (.pclk, .presetn, .step_fwd(sf), .step_rev(sr), .step_both(sb),
    .index_req(ix), .phase_a(fa), .phase_b(fb), .index_out(fi));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is seen high, then released
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) n_mismatch++;
  endtask : xfer
  task rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  // 9 cycles per level keeps every pin well past the filter
  task mv(input int k, input int cnt);
    repeat (cnt) begin
      sf <= (k == 1);
      sr <= (k == 2);
      sb <= (k == 3);
      @(posedge pclk);
      {sf, sr, sb} <= 3'h0;
      repeat (8) @(posedge pclk);
    end
  endtask : mv
  task ixp;
    ix <= 1'b1;
    repeat (9) @(posedge pclk);
    ix <= 1'b0;
    repeat (9) @(posedge pclk);
  endtask : ixp
  // ----------------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, sf, sr, sb, ix} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(qpv_pkg::OFF_MAXP, qpv_pkg::MAXP_RST);
    rc(qpv_pkg::OFF_VPER, qpv_pkg::VPER_RST);
    rc(8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h5);
    xfer(1'b1, qpv_pkg::OFF_POS, 32'ha);
    mv(1, 4);
    rc(qpv_pkg::OFF_POS, 32'he);
    mv(2, 2);
    rc(qpv_pkg::OFF_POS, 32'hc);
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h1);
    mv(1, 4);
    rc(qpv_pkg::OFF_POS, 32'he);
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h25);
    mv(1, 2);
    rc(qpv_pkg::OFF_POS, 32'hc);
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h11);
    mv(1, 4);
    rc(qpv_pkg::OFF_POS, 32'hd);
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h5);
    xfer(1'b1, qpv_pkg::OFF_IEN, 32'h1);
    mv(3, 1);
    rc(qpv_pkg::OFF_ISTAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rc(qpv_pkg::OFF_POS, 32'hd);
    xfer(1'b1, qpv_pkg::OFF_ICLR, 32'h1);
    rc(qpv_pkg::OFF_ISTAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, qpv_pkg::OFF_MAXP, 32'h63);
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'hd);
    xfer(1'b1, qpv_pkg::OFF_POS, 32'h14);
    mv(2, 1);
    ixp();
    rc(qpv_pkg::OFF_POS, 32'h63);
    mv(1, 2);
    ixp();
    rc(qpv_pkg::OFF_POS, 32'h0);
    rc(qpv_pkg::OFF_STAT, 32'h3);
    xfer(1'b1, qpv_pkg::OFF_VPER, 32'd2000);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h5 | (k << 8));
      xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h7 | (k << 8));
      mv(1, 128);
      n = 0;
      do xfer(1'b0, qpv_pkg::OFF_ISTAT, 32'h0); while (q[2] !== 1'b1 && ++n < 999);
      if (n >= 999) n_mismatch++;
      rc(qpv_pkg::OFF_VEL, 32'd128 >> k);
      xfer(1'b1, qpv_pkg::OFF_ICLR, 32'h4);
    end
    xfer(1'b1, qpv_pkg::OFF_CTRL, 32'h2);
    mv(1, 8);
    repeat (2100) @(posedge pclk);
    rc(qpv_pkg::OFF_VEL, 32'h1);
    rc(qpv_pkg::OFF_POS, 32'h18);
    complete_run();
  end
endmodule : qpv_top_tb
`default_nettype wire
